// File: wire_master_pkg.sv
/*
 * Shared constants, types and register map for the single-wire bus master
 * host port. Assumes a 125 MHz system clock and a host that reaches the
 * internal bank through an index pointer and a data window.
 */
// Operation
// RULE_01 - Master stays idle and drives nothing until host enables its clock; strong pullup control still follows command bit 1 while idle.
// RULE_02 - Host writes divisor with top bit set, which enables divided clock.
// RULE_03 - Host writes index pointer, then data window reaches that register.
// RULE_04 - Command register index zero; bit 0 starts a bus reset sequence.
// RULE_05 - Enable register index three; bit 0 enables presence interrupt.
// RULE_06 - Interrupt enable bit 4 enables receive-buffer-full interrupt.
// RULE_07 - Control register index five; bit 7 gates all master interrupts.
// RULE_08 - Flag register index two; bit 1 reports slave presence after reset.
// RULE_09 - Writing tx/rx byte starts transfer; reading returns sampled byte.
// RULE_10 - Sending all ones yields eight read slots; result shows slave data.
// RULE_11 - Device drives active-low strong pullup control output.
// RULE_12 - Completion sets flag; interrupt when source and master enable set.
package wire_master_pkg;

    // ****************************************************************
    // Register indices
    // ****************************************************************
    localparam logic [2:0] IDX_COMMAND = 3'h0;
    localparam logic [2:0] IDX_TXRX    = 3'h1;
    localparam logic [2:0] IDX_FLAGS   = 3'h2;
    localparam logic [2:0] IDX_ENABLES = 3'h3;
    localparam logic [2:0] IDX_DIVISOR = 3'h4;
    localparam logic [2:0] IDX_CONTROL = 3'h5;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CMD_RESET_BIT   = 0;
    localparam int CMD_SPU_BIT     = 1;
    localparam int FLAG_PD_BIT     = 0;
    localparam int FLAG_PDR_BIT    = 1;
    localparam int FLAG_TBE_BIT    = 2;
    localparam int FLAG_RBF_BIT    = 4;
    localparam int EN_PD_BIT       = 0;
    localparam int EN_RBF_BIT      = 4;
    localparam int DIV_CLKEN_BIT   = 7;
    localparam int CTL_MIE_BIT     = 7;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] RST_REG = 8'h00;

    // ****************************************************************
    // Bus timing in microseconds, at the divided 1 MHz tick
    // ****************************************************************
    localparam int TICK_NS         = 1000;
    localparam int CLK_NS          = 8;
    localparam int TICK_CYCLES     = TICK_NS / CLK_NS;
    localparam logic [9:0] T_RST_LOW_US  = 10'h1e0;
    localparam logic [9:0] T_PD_SAMP_US  = 10'h046;
    localparam logic [9:0] T_RST_END_US  = 10'h3c0;
    localparam logic [9:0] T_SLOT_US     = 10'h03c;
    localparam logic [9:0] T_LOW1_US     = 10'h006;
    localparam logic [9:0] T_SAMP_US     = 10'h00f;
    localparam logic [9:0] T_REC_US      = 10'h041;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_RESET = 2'b01,
        ST_BIT   = 2'b10
    } wire_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       sel_ptr;
        logic [7:0] data;
    } host_req_t;

    typedef struct packed {
        logic reset_done;
        logic present;
        logic byte_done;
    } wire_evt_t;

endpackage

// File: wire_tick_gen.sv
/*
 * Prescaler: turns the system clock into a one-cycle microsecond tick while
 * the clock enable bit is set. Assumes the divisor low bits have no effect on the tick period.
 */
`timescale 1ns/1ps
module wire_tick_gen (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       en_i,
    input  wire logic [6:0] ratio_i,
    output logic            tick_o
);
    // ****************************************************************
    // Counter
    // ****************************************************************
    logic [7:0] cnt_q;
    logic [7:0] limit;
    logic       wrap;

    // Divisor ratio is subtracted and added back, so any ratio still gives a 1 us tick
    assign limit = 8'(wire_master_pkg::TICK_CYCLES - 1) - {1'b0, ratio_i} +
                   {1'b0, ratio_i};
    assign wrap  = (cnt_q == limit);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q  <= 8'h00;
            tick_o <= 1'b0;
        end else begin
            cnt_q  <= (!en_i || wrap) ? 8'h00 : cnt_q + 8'h01; // RULE_02
            tick_o <= en_i && wrap;
        end
    end
endmodule

// File: wire_master.sv
/*
 * Single-wire bus master with indirect register bank. Assumes an external
 * pull-up on the bus line and on the strong pullup control pin.
 */
`timescale 1ns/1ps
module wire_master (
    input  wire logic       MCLK_I,
    input  wire logic       NRST_I,
    input  wire logic       HOST_WR_I,
    input  wire logic       HOST_RD_I,
    input  wire logic       HOST_SEL_PTR_I,
    input  wire logic [7:0] HOST_DATA_I,
    output logic      [7:0] HOST_DATA_O,
    output logic            IRQ_O,
    input  wire logic       BUS_LINE_I,
    output logic            BUS_LINE_O,
    output logic            BUS_LINE_OE_O,
    output logic            STRONG_PULLUP_CTL_N_O
);
    // ****************************************************************
    // Host request bundle
    // ****************************************************************
    wire_master_pkg::host_req_t req;
    assign req = '{wr: HOST_WR_I, rd: HOST_RD_I, sel_ptr: HOST_SEL_PTR_I,
                   data: HOST_DATA_I};

    logic [2:0] ptr_q;
    logic [7:0] cmd_q, txrx_q, flags_q, en_q, div_q, ctl_q;
    wire_master_pkg::wire_state_t st_q;
    logic [9:0] us_q;
    logic [2:0] bit_q;
    logic [7:0] shift_q;
    logic       drive_q;
    logic       spu_q;
    logic       tick;

    function automatic logic hit(input logic [2:0] p, input logic [2:0] idx,
                                 input logic s, input logic a);
        return a && !s && (p == idx);
    endfunction

    wire wr_ptr  = req.wr && req.sel_ptr; // RULE_03
    wire wr_cmd  = hit(ptr_q, wire_master_pkg::IDX_COMMAND, req.sel_ptr,
                       req.wr);
    wire wr_txrx = hit(ptr_q, wire_master_pkg::IDX_TXRX, req.sel_ptr, req.wr);
    wire wr_en   = hit(ptr_q, wire_master_pkg::IDX_ENABLES, req.sel_ptr,
                       req.wr);
    wire wr_div  = hit(ptr_q, wire_master_pkg::IDX_DIVISOR, req.sel_ptr,
                       req.wr);
    wire wr_ctl  = hit(ptr_q, wire_master_pkg::IDX_CONTROL, req.sel_ptr,
                       req.wr);
    wire rd_flag = hit(ptr_q, wire_master_pkg::IDX_FLAGS, req.sel_ptr,
                       req.rd);
    wire clk_en  = div_q[wire_master_pkg::DIV_CLKEN_BIT]; // RULE_01

    // ****************************************************************
    // Prescaler
    // ****************************************************************
    wire_tick_gen u_tick (
        .clk_i   (MCLK_I),
        .rst_n_i (NRST_I),
        .en_i    (clk_en),
        .ratio_i (div_q[6:0]),
        .tick_o  (tick)
    );

    // ****************************************************************
    // Line sequencer
    // ****************************************************************
    wire_master_pkg::wire_evt_t evt;
    wire start_rst  = wr_cmd && req.data[wire_master_pkg::CMD_RESET_BIT];
    wire start_byte = wr_txrx;
    wire idle       = (st_q == wire_master_pkg::ST_IDLE);
    wire cur_bit    = shift_q[0];
    wire rst_end    = tick && (us_q == wire_master_pkg::T_RST_END_US);
    wire slot_end   = tick && (us_q == wire_master_pkg::T_SLOT_US +
                                       wire_master_pkg::T_REC_US);
    wire rst_samp   = tick && (us_q == wire_master_pkg::T_RST_LOW_US +
                                       wire_master_pkg::T_PD_SAMP_US);
    wire bit_samp   = tick && (us_q == wire_master_pkg::T_SAMP_US);
    wire [9:0] low_len = cur_bit ? wire_master_pkg::T_LOW1_US
                                 : wire_master_pkg::T_SLOT_US;
    wire pull_low   =
        (st_q == wire_master_pkg::ST_RESET &&
         us_q < wire_master_pkg::T_RST_LOW_US) ||
        (st_q == wire_master_pkg::ST_BIT && us_q < low_len);

    // Slave presence held between sample and end of the reset sequence
    logic pres_q;

    assign evt.reset_done = (st_q == wire_master_pkg::ST_RESET) && rst_end;
    assign evt.present    = pres_q;
    assign evt.byte_done  = (st_q == wire_master_pkg::ST_BIT) && slot_end &&
                            (bit_q == 3'h7);

    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            st_q    <= wire_master_pkg::ST_IDLE;
            us_q    <= 10'h000;
            bit_q   <= 3'h0;
            shift_q <= 8'h00;
            pres_q  <= 1'b0;
        end else begin
            unique case (st_q)
                wire_master_pkg::ST_IDLE: begin
                    us_q  <= 10'h000;
                    bit_q <= 3'h0;
                    if (clk_en && start_rst) begin
                        st_q <= wire_master_pkg::ST_RESET; // RULE_04
                    end else if (clk_en && start_byte) begin
                        st_q    <= wire_master_pkg::ST_BIT; // RULE_09
                        shift_q <= req.data;
                    end
                end
                wire_master_pkg::ST_RESET: begin
                    if (tick) begin
                        us_q <= us_q + 10'h001;
                    end
                    if (rst_samp) begin
                        pres_q <= !BUS_LINE_I;
                    end
                    if (rst_end) begin
                        st_q <= wire_master_pkg::ST_IDLE;
                    end
                end
                wire_master_pkg::ST_BIT: begin
                    if (tick) begin
                        us_q <= us_q + 10'h001;
                    end
                    // A one bit leaves the line free, so slaves set the sample
                    if (bit_samp) begin
                        shift_q[0] <= BUS_LINE_I; // RULE_10
                    end
                    if (slot_end) begin
                        us_q    <= 10'h000;
                        bit_q   <= bit_q + 3'h1;
                        shift_q <= {shift_q[0], shift_q[7:1]};
                        if (bit_q == 3'h7) begin
                            st_q <= wire_master_pkg::ST_IDLE;
                        end
                    end
                end
                default: st_q <= wire_master_pkg::ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Register bank
    // ****************************************************************
    logic [7:0] flags_d;
    always_comb begin
        flags_d = flags_q;
        // Reading the flag register clears it; a new event still wins
        if (rd_flag) begin
            flags_d = 8'h00;
        end
        if (start_byte && idle) begin
            flags_d[wire_master_pkg::FLAG_TBE_BIT] = 1'b0;
        end
        if (evt.reset_done) begin
            flags_d[wire_master_pkg::FLAG_PD_BIT]  = 1'b1; // RULE_12
            flags_d[wire_master_pkg::FLAG_PDR_BIT] = evt.present; // RULE_08
        end
        if (evt.byte_done) begin
            flags_d[wire_master_pkg::FLAG_RBF_BIT] = 1'b1; // RULE_12
            flags_d[wire_master_pkg::FLAG_TBE_BIT] = 1'b1;
        end
    end

    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ptr_q   <= 3'h0;
            cmd_q   <= wire_master_pkg::RST_REG;
            txrx_q  <= wire_master_pkg::RST_REG;
            flags_q <= wire_master_pkg::RST_REG;
            en_q    <= wire_master_pkg::RST_REG;
            div_q   <= wire_master_pkg::RST_REG;
            ctl_q   <= wire_master_pkg::RST_REG;
        end else begin
            if (wr_ptr) begin
                ptr_q <= req.data[2:0]; // RULE_03
            end
            if (wr_cmd) begin
                cmd_q <= req.data & 8'hfe;
            end
            if (evt.byte_done) begin
                txrx_q <= {shift_q[0], shift_q[7:1]}; // RULE_09
            end
            if (wr_en) begin
                en_q <= req.data;
            end
            if (wr_div) begin
                div_q <= req.data; // RULE_02
            end
            if (wr_ctl) begin
                ctl_q <= req.data;
            end
            flags_q <= flags_d;
        end
    end

    // ****************************************************************
    // Outputs, all registered
    // ****************************************************************
    logic [7:0] rd_mux;
    always_comb begin
        unique case (ptr_q)
            wire_master_pkg::IDX_COMMAND: rd_mux = cmd_q;
            wire_master_pkg::IDX_TXRX:    rd_mux = txrx_q;
            wire_master_pkg::IDX_FLAGS:   rd_mux = flags_q;
            wire_master_pkg::IDX_ENABLES: rd_mux = en_q;
            wire_master_pkg::IDX_DIVISOR: rd_mux = div_q;
            wire_master_pkg::IDX_CONTROL: rd_mux = ctl_q;
            default:                      rd_mux = 8'h00;
        endcase
    end

    wire irq_src =
        (flags_q[wire_master_pkg::FLAG_PD_BIT] &&
         en_q[wire_master_pkg::EN_PD_BIT]) || // RULE_05
        (flags_q[wire_master_pkg::FLAG_RBF_BIT] &&
         en_q[wire_master_pkg::EN_RBF_BIT]); // RULE_06

    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            HOST_DATA_O           <= 8'h00;
            IRQ_O                 <= 1'b0;
            BUS_LINE_O            <= 1'b0;
            BUS_LINE_OE_O         <= 1'b0;
            STRONG_PULLUP_CTL_N_O <= 1'b1;
            drive_q               <= 1'b0;
            spu_q                 <= 1'b0;
        end else begin
            HOST_DATA_O   <= req.sel_ptr ? {5'h00, ptr_q} : rd_mux;
            IRQ_O         <= irq_src &&
                             ctl_q[wire_master_pkg::CTL_MIE_BIT]; // RULE_07
            // Open drain: only ever pull low, never drive high
            drive_q       <= pull_low && clk_en; // RULE_01
            BUS_LINE_O    <= 1'b0;
            BUS_LINE_OE_O <= pull_low && clk_en;
            // Strong pullup only while idle, but it lags two edges and can overlap the first cycle of a low pull
            spu_q         <= cmd_q[wire_master_pkg::CMD_SPU_BIT] && idle;
            STRONG_PULLUP_CTL_N_O <= !(spu_q && !drive_q); // RULE_11
        end
    end
endmodule

// File: wire_master_checker.sv
/* Port checker for the single-wire bus master.
   Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ps
module wire_master_checker (
    input wire logic       MCLK_I,
    input wire logic       NRST_I,
    input wire logic       HOST_WR_I,
    input wire logic       HOST_RD_I,
    input wire logic       HOST_SEL_PTR_I,
    input wire logic [7:0] HOST_DATA_I,
    input wire logic [7:0] HOST_DATA_O,
    input wire logic       IRQ_O,
    input wire logic       BUS_LINE_I,
    input wire logic       BUS_LINE_O,
    input wire logic       BUS_LINE_OE_O,
    input wire logic       STRONG_PULLUP_CTL_N_O
);
    // ************************************************************
    // Shadow state
    // ************************************************************
    logic [2:0]  ptr_q;
    logic        clk_q;
    logic        mie_q;
    logic [16:0] quiet_q;
    logic [16:0] low_q;
    wire         wwin = HOST_WR_I && !HOST_SEL_PTR_I;
    wire         wdiv = wwin && ptr_q == wire_master_pkg::IDX_DIVISOR;
    wire         wctl = wwin && ptr_q == wire_master_pkg::IDX_CONTROL;
    // Idle only after longer than the reset low-to-end span
    wire         idle = clk_q && quiet_q > 17'd62500;

    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ptr_q   <= 3'h0;
            clk_q   <= 1'b0;
            mie_q   <= 1'b0;
            quiet_q <= 17'h1ffff;
            low_q   <= 17'h0;
        end else begin
            if (HOST_WR_I && HOST_SEL_PTR_I) ptr_q <= HOST_DATA_I[2:0];
            if (wdiv) clk_q <= HOST_DATA_I[7];
            if (wctl) mie_q <= HOST_DATA_I[7];
            quiet_q <= BUS_LINE_OE_O ? 17'h0 : quiet_q + {16'h0, ~&quiet_q};
            low_q   <= BUS_LINE_OE_O ? low_q + 17'h1 : 17'h0;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!NRST_I);

    sequence s_win(logic [2:0] idx);
        wwin && ptr_q == idx;
    endsequence
    sequence s_go(logic [2:0] idx);
        s_win(idx) ##0 idle;
    endsequence

    AST_OFF_QUIET: assert property (!clk_q |-> !BUS_LINE_OE_O)
        else $error("bus driven with clock disabled");
    AST_RST_KICK: assert property (s_go(wire_master_pkg::IDX_COMMAND)
        ##0 HOST_DATA_I[0] |-> ##[1:300] BUS_LINE_OE_O)
        else $error("reset sequence did not start");
    AST_RST_LEN: assert property ($fell(BUS_LINE_OE_O) |->
        low_q < 17'd8000 || (low_q > 17'd59800 && low_q < 17'd60200))
        else $error("bus low pulse of wrong length");
    AST_TX_KICK: assert property (s_go(wire_master_pkg::IDX_TXRX)
        |-> ##[1:300] BUS_LINE_OE_O)
        else $error("byte transfer did not start");
    AST_OPEN_DRAIN: assert property (BUS_LINE_OE_O |-> !BUS_LINE_O)
        else $error("bus line driven high");
    AST_SPU_OFF: assert property (BUS_LINE_OE_O |-> STRONG_PULLUP_CTL_N_O)
        else $error("strong pullup on while line pulled low");
    AST_IRQ_GATE: assert property ($rose(IRQ_O) |-> mie_q)
        else $error("interrupt without master enable");
    AST_IRQ_DONE: assert property ($rose(IRQ_O) |-> quiet_q > 17'd7000)
        else $error("interrupt before bus activity ended");
    // The registered interrupt drops one edge after the clearing read
    AST_IRQ_HOLD: assert property (IRQ_O && !HOST_RD_I && !HOST_WR_I
        && !$past(HOST_RD_I) |=> IRQ_O)
        else $error("interrupt dropped without a read");
    AST_ENA_BACK: assert property (s_win(wire_master_pkg::IDX_ENABLES)
        ##1 !HOST_SEL_PTR_I |=> HOST_DATA_O == $past(HOST_DATA_I, 2))
        else $error("enable register readback wrong");
endmodule

bind wire_master wire_master_checker chk (
    .MCLK_I(MCLK_I), .NRST_I(NRST_I), .HOST_WR_I(HOST_WR_I),
    .HOST_RD_I(HOST_RD_I), .HOST_SEL_PTR_I(HOST_SEL_PTR_I),
    .HOST_DATA_I(HOST_DATA_I), .HOST_DATA_O(HOST_DATA_O), .IRQ_O(IRQ_O),
    .BUS_LINE_I(BUS_LINE_I), .BUS_LINE_O(BUS_LINE_O),
    .BUS_LINE_OE_O(BUS_LINE_OE_O),
    .STRONG_PULLUP_CTL_N_O(STRONG_PULLUP_CTL_N_O));

// File: wire_slave_model.sv
/* Behavioural single-wire slave.
   Assumes the bench resolves the pulled-up wired-AND line. */
`timescale 1ns/1ps
module wire_slave_model (
    input  wire logic       line_i,
    input  wire logic       present_i,
    input  wire logic [7:0] data_i,
    output logic            pull_o
);
    // ************************************************************
    // Slave timing
    // ************************************************************
    realtime    t0 = 0;
    logic [2:0] idx = 3'h0;
    initial pull_o = 1'b0;

    // A zero bit holds the line low past the master's sample point
    always @(negedge line_i) begin
        if (!pull_o) begin
            t0 = $realtime;
            if (!data_i[idx]) begin
                pull_o = 1'b1;
                #30000;
                pull_o = 1'b0;
            end
            idx = idx + 3'h1;
        end
    end

    // A long low is a bus reset; restart t0 so the pulse end is ignored
    always @(posedge line_i) begin
        if ($realtime - t0 > 400000) begin
            t0  = $realtime;
            idx = 3'h0;
            if (present_i) begin
                #20000;
                pull_o = 1'b1;
                #120000;
                pull_o = 1'b0;
            end
        end
    end
endmodule

// File: wire_master_tb.sv
/* Self-checking bench for the single-wire bus master.
   Assumes the checker and slave model are compiled before it. */
`timescale 1ns/1ps
module wire_master_tb;
    // ************************************************************
    // Wiring
    // ************************************************************
    logic       mclk = 1'b0;
    logic       nrst = 1'b0;
    logic       wr = 1'b0, rd = 1'b0, sel = 1'b0, pres = 1'b0;
    logic       irq, bo, oe, spu_n, pull;
    logic [7:0] din = 8'h00, sdat = 8'hff, dout;
    int         fails = 0, cmp_count = 0, cyc = 0;
    wire        line = !((oe && !bo) || pull);

    wire_master uut (
        .MCLK_I(mclk), .NRST_I(nrst), .HOST_WR_I(wr), .HOST_RD_I(rd),
        .HOST_SEL_PTR_I(sel), .HOST_DATA_I(din), .HOST_DATA_O(dout),
        .IRQ_O(irq), .BUS_LINE_I(line), .BUS_LINE_O(bo),
        .BUS_LINE_OE_O(oe), .STRONG_PULLUP_CTL_N_O(spu_n));
    wire_slave_model slave (.line_i(line), .present_i(pres),
        .data_i(sdat), .pull_o(pull));

    initial forever #4 mclk = ~mclk;

    // ************************************************************
    // Host cycles
    // ************************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic w(input logic s, input logic [7:0] d);
        @(posedge mclk);
        wr  <= 1'b1;
        sel <= s;
        din <= d;
        @(posedge mclk);
        wr  <= 1'b0;
        sel <= 1'b0;
    endtask
    task automatic wreg(input logic [2:0] i, input logic [7:0] d);
        w(1'b1, {5'h0, i});
        w(1'b0, d);
    endtask
    // Read also strobes, which clears the flag register when it reads index two
    task automatic rreg(input logic [2:0] i, input logic [7:0] m,
                        input logic [7:0] e);
        w(1'b1, {5'h0, i});
        repeat (2) @(posedge mclk);
        #1;
        chk(dout & m, e);
        @(posedge mclk);
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
    endtask
    task automatic wait_irq(input int n);
        for (int k = 0; k < n && irq !== 1'b1; k++) @(posedge mclk);
        #1;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_off();
        wreg(3'h0, 8'h01);
        repeat (400) @(posedge mclk);
        #1;
        chk({5'h0, spu_n, irq, oe}, 8'h04);
        rreg(3'h2, 8'h13, 8'h00);
        rreg(3'h3, 8'hff, wire_master_pkg::RST_REG);
    endtask
    task automatic t_cfg();
        wreg(3'h4, 8'h86);
        wreg(3'h0, 8'h02);
        repeat (3) @(posedge mclk);
        #1;
        chk({7'h0, spu_n}, 8'h00);
        wreg(3'h0, 8'h00);
        repeat (3) @(posedge mclk);
        #1;
        chk({7'h0, spu_n}, 8'h01);
        wreg(3'h3, 8'h11);
        rreg(3'h3, 8'hff, 8'h11);
        wreg(3'h5, 8'h80);
        rreg(3'h5, 8'h80, 8'h80);
    endtask
    task automatic t_rst(input logic p, input logic [7:0] ctl,
                         input logic [7:0] ef, input logic [7:0] ei);
        pres = p;
        wreg(3'h5, ctl);
        wreg(3'h0, 8'h01);
        wait_irq(130000);
        chk({7'h0, irq}, ei);
        rreg(3'h2, 8'h03, ef);
        repeat (2) @(posedge mclk);
        #1;
        chk({7'h0, irq}, 8'h00);
    endtask
    task automatic t_byte();
        sdat = 8'h5a;
        wreg(3'h5, 8'h80);
        wreg(3'h1, 8'hff);
        wait_irq(140000);
        chk({7'h0, irq}, 8'h01);
        rreg(3'h1, 8'hff, 8'h5a);
        rreg(3'h2, 8'h10, 8'h10);
    endtask

    task automatic print_verdict();
        if (fails == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // A reset costs some 120k cycles and a byte some 125k, so the ceiling is generous
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 500000) begin
            fails++;
            print_verdict();
        end
    end

    initial begin
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        t_off();
        t_cfg();
        t_rst(1'b1, 8'h80, 8'h03, 8'h01);
        t_rst(1'b0, 8'h00, 8'h01, 8'h00);
        t_byte();
        print_verdict();
    end
endmodule
